// file: rtl/tpic_top.v
// Configuration registers and prescalers of timers 0 and 1, start/reset control and interrupt requests of three timers.
//
// Functional notes
// - Each timer requests interrupts on stop, rising, falling or both output edges.
// - Control bit 6 picks counter-stop interrupts at 0, output-edge interrupts at 1.
// - Control bits 5:4 pick falling 00, rising 01, both 10; 11 unused.
// - Rising-edge and both-edge modes also request when the timer starts.
// - First PWM interrupt suppressed when compare is 0, 255 or below reload.
// - Stop mode with level external start: pin falling low requests, even while timer off; if it stops a running timer, a second request follows a cycle later.
// - Falling-edge mode: asserting the timer reset raises a request.
// - Timer 0 control bit 0: 0 holds internal reset, 1 releases.
// - Timer 0 control bit 1: external reset level 0, edge 1.
// - Timer 0 control bit 2: internal stop 0, internal start 1.
// - Timer 0 control bit 3: external start level 0, edge 1.
// - Prescaler bits 4:0 divide master clock by two to the code, up to 65536.
// - Clock-select bit 5: pulse output waveform 0, square waveform 1.
// - Timer 0 reset source bits 1:0: internal, external, either; 11 unused.
// - Timer 0 start source bits 3:2: internal, external, either; 11 unused.
// - Source register holds sync holds: timer 0 bit 5, timer 2 bit 6, timer 1 bit 7.
// - Timer 1 control has only internal reset and run; bits 1 and 3 unused.
// - Control bit 7 selects timer mode at 0, PWM mode at 1.
// - A set sync hold bit keeps its timer in reset for joint starts.
// - Timer 0 counts master clock or external clock pin; others master clock only.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
module tpic_top (
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_rst,
    // Register port
    input  wire [2:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output wire [7:0] o_rdata,
    // Timer 0 external pins
    input  wire       i_t0_start_stop_pin,
    input  wire       i_t0_reset_pin,
    input  wire       i_t0_ext_clk_pin,
    // Timer 2 control byte kept elsewhere
    input  wire [7:0] i_t2_control,
    // Datapath feedback, index 0 to 2 for timers 0 to 2
    input  wire [2:0] i_timer_wave_out,
    input  wire [2:0] i_count_stop,
    input  wire [7:0] i_t0_compare,
    input  wire [7:0] i_t0_reload,
    input  wire [7:0] i_t1_compare,
    input  wire [7:0] i_t1_reload,
    input  wire [7:0] i_t2_compare,
    input  wire [7:0] i_t2_reload,
    // Controls to the datapath
    output wire [2:0] o_timer_reset,
    output wire [2:0] o_timer_run,
    output wire [1:0] o_pwm_select,
    output wire [1:0] o_square_wave,
    output wire [1:0] o_prescaled_tick,
    // Requests to the interrupt controller
    output wire [2:0] o_irq
);
`include "tpic_defs.vh"

    reg  [7:0]  t0_control_r;
    reg  [7:0]  t0_clock_select_r;
    reg  [7:0]  t0_source_and_sync_r;
    reg  [7:0]  t1_control_r;
    reg  [7:0]  t1_clock_select_r;
    reg  [7:0]  rdata_r;
    reg  [7:0]  rdata_nxt;
    reg         t0_str_pin_d_r;
    reg         t0_rst_pin_d_r;
    reg         t0_ext_clk_d_r;
    reg         t0_edge_run_r;
    reg         t0_edge_run_nxt;
    reg  [2:0]  run_d_r;
    reg  [2:0]  reset_r;
    reg  [2:0]  run_r;
    wire [1:0]  prescaled_tick;

    wire [1:0]  t0_reset_source;
    wire [1:0]  t0_start_source;
    wire        t0_clock_source;
    wire        t0_sync_hold;
    wire        t1_sync_hold;
    wire        t2_sync_hold;
    wire        t0_str_rise;
    wire        t0_str_fall;
    wire        t0_rst_rise;
    wire        t0_ext_reset;
    wire        t0_int_reset;
    wire        t0_ext_run;
    wire        t0_int_run;
    wire [2:0]  reset_nxt;
    wire [2:0]  run_nxt;
    wire [2:0]  start_evt;
    wire [2:0]  stop_evt;
    wire [1:0]  div_step;
    wire [4:0]  div_code [0:1];
    wire [2:0]  src_sel;
    wire [5:0]  edge_sel;
    wire [2:0]  pwm_sel;
    wire [23:0] compare;
    wire [23:0] reload;
    wire        t0_stop_pin_evt;

    // Mask of prescaler bits that must all be set for one divided tick.
    function [15:0] tpic_div_mask;
        input [4:0] code;
        reg   [4:0] c;
        begin
            c = (code > `TPIC_DIV_MAX) ? `TPIC_DIV_MAX : code;
            tpic_div_mask = (c == `TPIC_DIV_MAX) ? 16'hffff : ((16'h0001 << c) - 16'h0001);
        end
    endfunction

    // Source selection test shared by reset and start paths.
    function tpic_use_ext;
        input [1:0] src;
        begin
            tpic_use_ext = (src == `TPIC_SRC_EXT) || (src == `TPIC_SRC_EITHER);
        end
    endfunction

    function tpic_use_int;
        input [1:0] src;
        begin
            tpic_use_int = (src == `TPIC_SRC_INT) || (src == `TPIC_SRC_EITHER);
        end
    endfunction

    // Register writes.
    always @(posedge i_clk) begin
        if (i_rst) begin
            t0_control_r         <= `TPIC_RST_T0_CTRL;
            t0_clock_select_r    <= `TPIC_RST_T0_CLKSEL;
            t0_source_and_sync_r <= `TPIC_RST_T0_SRC;
            t1_control_r         <= `TPIC_RST_T1_CTRL;
            t1_clock_select_r    <= `TPIC_RST_T1_CLKSEL;
        end else if (i_wr) begin
            case (i_addr)
                `TPIC_OFF_T0_CTRL: begin
                    t0_control_r <= i_wdata;
                end
                `TPIC_OFF_T0_CLKSEL: begin
                    t0_clock_select_r <= i_wdata & `TPIC_CLKSEL_MASK;
                end
                `TPIC_OFF_T0_SRC: begin
                    t0_source_and_sync_r <= i_wdata;
                end
                `TPIC_OFF_T1_CTRL: begin
                    t1_control_r <= i_wdata & `TPIC_T1_CTRL_MASK;
                end
                `TPIC_OFF_T1_CLKSEL: begin
                    t1_clock_select_r <= i_wdata & `TPIC_CLKSEL_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Read data stands in the cycle after the read strobe only.
    always @* begin
        rdata_nxt = 8'h00;
        if (i_rd) begin
            case (i_addr)
                `TPIC_OFF_T0_CTRL:   rdata_nxt = t0_control_r;
                `TPIC_OFF_T0_CLKSEL: rdata_nxt = t0_clock_select_r;
                `TPIC_OFF_T0_SRC:    rdata_nxt = t0_source_and_sync_r;
                `TPIC_OFF_T1_CTRL:   rdata_nxt = t1_control_r;
                `TPIC_OFF_T1_CLKSEL: rdata_nxt = t1_clock_select_r;
                `TPIC_OFF_STATUS:    rdata_nxt = {2'h0, reset_r[2], run_r[2],
                                                  reset_r[1], run_r[1], reset_r[0], run_r[0]};
                default:             rdata_nxt = 8'h00;
            endcase
        end
    end

    always @(posedge i_clk) begin
        if (i_rst)
            rdata_r <= 8'h00;
        else
            rdata_r <= rdata_nxt;
    end

    assign o_rdata = rdata_r;

    // Field extraction.
    assign t0_reset_source = t0_source_and_sync_r[`TPIC_B_RST_SRC_HI:`TPIC_B_RST_SRC_LO];
    assign t0_start_source = t0_source_and_sync_r[`TPIC_B_STR_SRC_HI:`TPIC_B_STR_SRC_LO];
    assign t0_clock_source = t0_source_and_sync_r[`TPIC_B_CLK_SRC];
    assign t0_sync_hold    = t0_source_and_sync_r[`TPIC_B_T0_HOLD];
    assign t2_sync_hold    = t0_source_and_sync_r[`TPIC_B_T2_HOLD];
    assign t1_sync_hold    = t0_source_and_sync_r[`TPIC_B_T1_HOLD];

    // Timer 0 external pin edges.
    assign t0_str_rise = i_t0_start_stop_pin & ~t0_str_pin_d_r;
    assign t0_str_fall = ~i_t0_start_stop_pin & t0_str_pin_d_r;
    assign t0_rst_rise = i_t0_reset_pin & ~t0_rst_pin_d_r;

    // External reset is the pin level, or a one-cycle pulse on its rising edge.
    assign t0_ext_reset = t0_control_r[`TPIC_B_EXT_RST_EDGE] ? t0_rst_rise :
                          i_t0_reset_pin;
    assign t0_int_reset = ~t0_control_r[`TPIC_B_INT_RESET_N];

    // Edge start: first rising edge after reset starts, the next one stops.
    always @* begin
        t0_edge_run_nxt = t0_edge_run_r;
        if (t0_str_rise)
            t0_edge_run_nxt = ~t0_edge_run_r;
        if (reset_nxt[0])
            t0_edge_run_nxt = 1'b0;
    end

    assign t0_ext_run = t0_control_r[`TPIC_B_EXT_STR_EDGE] ? t0_edge_run_r :
                        i_t0_start_stop_pin;
    assign t0_int_run = t0_control_r[`TPIC_B_INT_RUN];

    // Reset and run of each timer.
    assign reset_nxt[0] = (tpic_use_int(t0_reset_source) & t0_int_reset) |
                          (tpic_use_ext(t0_reset_source) & t0_ext_reset) |
                          t0_sync_hold;
    assign reset_nxt[1] = ~t1_control_r[`TPIC_B_INT_RESET_N] | t1_sync_hold;
    assign reset_nxt[2] = ~i_t2_control[`TPIC_B_INT_RESET_N] | t2_sync_hold;
    assign run_nxt[0]   = ~reset_nxt[0] &
                          ((tpic_use_int(t0_start_source) & t0_int_run) |
                           (tpic_use_ext(t0_start_source) & t0_ext_run));
    assign run_nxt[1]   = ~reset_nxt[1] & t1_control_r[`TPIC_B_INT_RUN];
    assign run_nxt[2]   = ~reset_nxt[2] & i_t2_control[`TPIC_B_INT_RUN];

    always @(posedge i_clk) begin
        if (i_rst) begin
            t0_str_pin_d_r <= 1'b0;
            t0_rst_pin_d_r <= 1'b0;
            t0_ext_clk_d_r <= 1'b0;
            t0_edge_run_r  <= 1'b0;
            reset_r        <= 3'h7;
            run_r          <= 3'h0;
            run_d_r        <= 3'h0;
        end else begin
            t0_str_pin_d_r <= i_t0_start_stop_pin;
            t0_rst_pin_d_r <= i_t0_reset_pin;
            t0_ext_clk_d_r <= i_t0_ext_clk_pin;
            t0_edge_run_r  <= t0_edge_run_nxt;
            reset_r        <= reset_nxt;
            run_r          <= run_nxt;
            run_d_r        <= run_r;
        end
    end

    assign start_evt = run_r & ~run_d_r;

    // External start in level mode falling low while stop interrupts are chosen.
    assign t0_stop_pin_evt = tpic_use_ext(t0_start_source) &
                             ~t0_control_r[`TPIC_B_EXT_STR_EDGE] & t0_str_fall;
    assign stop_evt = i_count_stop | (~run_r & run_d_r) | {2'h0, t0_stop_pin_evt};

    assign o_timer_reset = reset_r;
    assign o_timer_run   = run_r;
    assign o_pwm_select  = {t1_control_r[`TPIC_B_PWM], t0_control_r[`TPIC_B_PWM]};
    assign o_square_wave = {t1_clock_select_r[`TPIC_B_WAVE],
                            t0_clock_select_r[`TPIC_B_WAVE]};

    // Prescalers; timer 0 may step on the external clock pin instead.
    assign div_code[0] = t0_clock_select_r[`TPIC_B_DIV_HI:`TPIC_B_DIV_LO];
    assign div_code[1] = t1_clock_select_r[`TPIC_B_DIV_HI:`TPIC_B_DIV_LO];
    assign div_step[0] = t0_clock_source ? (i_t0_ext_clk_pin & ~t0_ext_clk_d_r) :
                         1'b1;
    assign div_step[1] = 1'b1;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_div
            wire [15:0] mask;
            wire        hit;
            reg  [15:0] cnt_r;
            reg         tick_r;
            assign mask = tpic_div_mask(div_code[g]);
            assign hit  = div_step[g] & ((cnt_r & mask) == mask);
            always @(posedge i_clk) begin
                if (i_rst || reset_r[g]) begin
                    cnt_r  <= 16'h0000;
                    tick_r <= 1'b0;
                end else begin
                    if (div_step[g])
                        cnt_r <= hit ? 16'h0000 : cnt_r + 16'h0001;
                    tick_r <= hit & run_r[g];
                end
            end
            assign prescaled_tick[g] = tick_r;
        end
    endgenerate

    assign o_prescaled_tick = prescaled_tick;

    // Interrupt request generators.
    assign src_sel  = {i_t2_control[`TPIC_B_IRQ_SRC], t1_control_r[`TPIC_B_IRQ_SRC],
                       t0_control_r[`TPIC_B_IRQ_SRC]};
    assign edge_sel = {i_t2_control[`TPIC_B_EDGE_HI:`TPIC_B_EDGE_LO],
                       t1_control_r[`TPIC_B_EDGE_HI:`TPIC_B_EDGE_LO],
                       t0_control_r[`TPIC_B_EDGE_HI:`TPIC_B_EDGE_LO]};
    assign pwm_sel  = {i_t2_control[`TPIC_B_PWM], t1_control_r[`TPIC_B_PWM],
                       t0_control_r[`TPIC_B_PWM]};
    assign compare  = {i_t2_compare, i_t1_compare, i_t0_compare};
    assign reload   = {i_t2_reload, i_t1_reload, i_t0_reload};

    generate
        for (g = 0; g < 3; g = g + 1) begin : g_irq
            tpic_irq u_irq (
                .i_clk         (i_clk),
                .i_rst         (i_rst),
                .i_src_sel     (src_sel[g]),
                .i_edge_sel    (edge_sel[2*g+1:2*g]),
                .i_pwm         (pwm_sel[g]),
                .i_wave        (i_timer_wave_out[g]),
                .i_start       (start_evt[g]),
                .i_stop        (stop_evt[g]),
                .i_timer_reset (reset_r[g]),
                .i_compare     (compare[8*g+7:8*g]),
                .i_reload      (reload[8*g+7:8*g]),
                .o_irq         (o_irq[g])
            );
        end
    endgenerate
endmodule

// file: rtl/tpic_defs.vh
// Register offsets, field positions and codes for the timer configuration block.
`ifndef TPIC_DEFS_VH
`define TPIC_DEFS_VH

`define TPIC_ADDR_W          3
`define TPIC_OFF_T0_CTRL     3'h0
`define TPIC_OFF_T0_CLKSEL   3'h1
`define TPIC_OFF_T0_SRC      3'h2
`define TPIC_OFF_T1_CTRL     3'h3
`define TPIC_OFF_T1_CLKSEL   3'h4
`define TPIC_OFF_STATUS      3'h5

`define TPIC_RST_T0_CTRL     8'h00
`define TPIC_RST_T0_CLKSEL   8'h00
`define TPIC_RST_T0_SRC      8'h00
`define TPIC_RST_T1_CTRL     8'h00
`define TPIC_RST_T1_CLKSEL   8'h00

`define TPIC_T1_CTRL_MASK    8'hf5
`define TPIC_CLKSEL_MASK     8'h3f

`define TPIC_B_INT_RESET_N   0
`define TPIC_B_EXT_RST_EDGE  1
`define TPIC_B_INT_RUN       2
`define TPIC_B_EXT_STR_EDGE  3
`define TPIC_B_EDGE_LO       4
`define TPIC_B_EDGE_HI       5
`define TPIC_B_IRQ_SRC       6
`define TPIC_B_PWM           7

`define TPIC_B_DIV_LO        0
`define TPIC_B_DIV_HI        4
`define TPIC_B_WAVE          5

`define TPIC_B_RST_SRC_LO    0
`define TPIC_B_RST_SRC_HI    1
`define TPIC_B_STR_SRC_LO    2
`define TPIC_B_STR_SRC_HI    3
`define TPIC_B_CLK_SRC       4
`define TPIC_B_T0_HOLD       5
`define TPIC_B_T2_HOLD       6
`define TPIC_B_T1_HOLD       7

`define TPIC_EDGE_FALL       2'h0
`define TPIC_EDGE_RISE       2'h1
`define TPIC_EDGE_BOTH       2'h2

`define TPIC_SRC_INT         2'h0
`define TPIC_SRC_EXT         2'h1
`define TPIC_SRC_EITHER      2'h2

`define TPIC_DIV_MAX         5'h10
`define TPIC_CMP_MIN         8'h00
`define TPIC_CMP_MAX         8'hff

`endif

// file: rtl/tpic_irq.v
// Interrupt request generator for one timer.
`timescale 1ns/1ps
module tpic_irq (
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_rst,
    // Mode selection
    input  wire       i_src_sel,
    input  wire [1:0] i_edge_sel,
    input  wire       i_pwm,
    // Timer state
    input  wire       i_wave,
    input  wire       i_start,
    input  wire       i_stop,
    input  wire       i_timer_reset,
    input  wire [7:0] i_compare,
    input  wire [7:0] i_reload,
    // Request to the interrupt controller
    output wire       o_irq
);
`include "tpic_defs.vh"

    reg  wave_d_r;
    reg  trst_d_r;
    reg  suppress_r;
    reg  suppress_nxt;
    reg  irq_r;
    reg  irq_nxt;
    wire rise;
    wire fall;
    wire want_rise;
    wire want_fall;
    wire edge_evt;
    wire no_pulse;
    wire suppress_now;

    assign rise      = i_wave & ~wave_d_r;
    assign fall      = ~i_wave & wave_d_r;
    assign want_rise = (i_edge_sel == `TPIC_EDGE_RISE) || (i_edge_sel == `TPIC_EDGE_BOTH);
    assign want_fall = (i_edge_sel == `TPIC_EDGE_FALL) || (i_edge_sel == `TPIC_EDGE_BOTH);
    // A PWM output that never toggles cannot give a first interrupt.
    assign no_pulse  = (i_compare == `TPIC_CMP_MIN) || (i_compare == `TPIC_CMP_MAX) ||
                       (i_compare < i_reload);
    assign edge_evt  = (want_rise & (rise | i_start)) |
                       (want_fall & fall) |
                       ((i_edge_sel == `TPIC_EDGE_FALL) & i_timer_reset & ~trst_d_r);

    // A start arms suppression in its own cycle, so the request raised by the start is covered.
    assign suppress_now = i_start ? (i_pwm & no_pulse) : suppress_r;

    always @* begin
        suppress_nxt = suppress_now;
        irq_nxt      = 1'b0;
        if (i_src_sel) begin
            irq_nxt = edge_evt & ~suppress_now;
            if (edge_evt)
                suppress_nxt = 1'b0;
        end else begin
            irq_nxt = i_stop;
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            wave_d_r   <= 1'b0;
            // Timers leave reset held, so no false reset edge follows release.
            trst_d_r   <= 1'b1;
            suppress_r <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            wave_d_r   <= i_wave;
            trst_d_r   <= i_timer_reset;
            suppress_r <= suppress_nxt;
            irq_r      <= irq_nxt;
        end
    end

    assign o_irq = irq_r;
endmodule

// file: bench/tpic_props.sv
// Port-level assertions for the timer configuration block.
`timescale 1ns/1ps
module tpic_props (
    // Clock and reset
    input wire       i_clk,
    input wire       i_rst,
    // Register port
    input wire [2:0] i_addr,
    input wire [7:0] i_wdata,
    input wire       i_wr,
    // Timer traffic
    input wire [2:0] i_timer_wave_out,
    input wire [2:0] i_count_stop,
    input wire [2:0] o_timer_reset,
    input wire [2:0] o_timer_run,
    input wire [1:0] o_pwm_select,
    input wire [1:0] o_square_wave,
    input wire [2:0] o_irq
);
    logic [7:0] ctl_r;
    logic [7:0] cks_r;
    logic [7:0] src_r;
    wire        edg = ctl_r[6] && !ctl_r[7];

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // Shadow copies of the timer 0 registers, so modes can be judged at the ports.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctl_r <= 8'h00;
            cks_r <= 8'h00;
            src_r <= 8'h00;
        end else if (i_wr) begin
            if (i_addr == 3'h0) ctl_r <= i_wdata;
            if (i_addr == 3'h1) cks_r <= i_wdata;
            if (i_addr == 3'h2) src_r <= i_wdata;
        end
    end

    sequence s_rise;
        $rose(i_timer_wave_out[0]);
    endsequence
    sequence s_fall;
        $fell(i_timer_wave_out[0]);
    endsequence
    sequence s_quiet;
        $stable(i_timer_wave_out[0]) && $stable(o_timer_run[0])
            && $stable(o_timer_reset[0]) && !i_count_stop[0];
    endsequence

    property p_rise_irq;
        (edg && ctl_r[5:4] == 2'h1) ##0 s_rise |=> o_irq[0];
    endproperty
    a_rise_irq: assert property (p_rise_irq) else $error("missed rising request");
    property p_fall_irq;
        (edg && ctl_r[5:4] == 2'h0) ##0 s_fall |=> o_irq[0];
    endproperty
    a_fall_irq: assert property (p_fall_irq) else $error("missed falling request");
    property p_both_irq;
        (edg && ctl_r[5:4] == 2'h2) ##0 (s_rise or s_fall) |=> o_irq[0];
    endproperty
    a_both_irq: assert property (p_both_irq) else $error("missed edge request");
    property p_once;
        (o_irq[0] && edg) ##0 s_quiet |=> !o_irq[0];
    endproperty
    a_once: assert property (p_once) else $error("request longer than one cycle");
    property p_pwm;
        o_pwm_select[0] == ctl_r[7];
    endproperty
    a_pwm: assert property (p_pwm) else $error("mode output differs");
    property p_square;
        o_square_wave[0] == cks_r[5];
    endproperty
    a_square: assert property (p_square) else $error("waveform output differs");
    property p_hold;
        src_r[5] || (!ctl_r[0] && src_r[1:0] == 2'h0) |=> o_timer_reset[0];
    endproperty
    a_hold: assert property (p_hold) else $error("timer not held in reset");
    property p_release;
        ctl_r[0] && src_r[1:0] == 2'h0 && !src_r[5] |=> !o_timer_reset[0];
    endproperty
    a_release: assert property (p_release) else $error("timer not released");
    property p_run;
        ctl_r[2] && ctl_r[0] && !src_r[5] && src_r[3:0] == 4'h0 && !o_timer_reset[0]
            |=> o_timer_run[0];
    endproperty
    a_run: assert property (p_run) else $error("timer not running");
    property p_stop;
        !ctl_r[2] && src_r[3:2] == 2'h0 |=> !o_timer_run[0];
    endproperty
    a_stop: assert property (p_stop) else $error("timer not stopped");
endmodule

bind tpic_top tpic_props chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_timer_wave_out(i_timer_wave_out), .i_count_stop(i_count_stop),
    .o_timer_reset(o_timer_reset), .o_timer_run(o_timer_run),
    .o_pwm_select(o_pwm_select), .o_square_wave(o_square_wave), .o_irq(o_irq)
);

// file: bench/tpic_far.sv
// Model of the interrupt controller and the timer 0 external pins.
`timescale 1ns/1ps
module tpic_far (
    // Clock
    input  wire       i_clk,
    // Requests from the timers
    input  wire [2:0] i_irq,
    // Timer 0 pins
    output logic      o_start_pin,
    output logic      o_reset_pin,
    output logic      o_ext_clk
);
    logic [7:0] irq_cnt;
    logic       irq_en;

    initial begin
        irq_cnt = 8'h00;
        irq_en = 1'b1;
        o_start_pin = 1'b0;
        o_reset_pin = 1'b0;
        o_ext_clk = 1'b0;
    end

    // Requests are ignored while software has the timer interrupt disabled.
    always @(posedge i_clk) begin
        if (irq_en && i_irq[0] === 1'b1) irq_cnt <= irq_cnt + 8'h01;
    end

    task clear;
        irq_cnt <= 8'h00;
    endtask
    task set_en(input logic v);
        irq_en <= v;
    endtask
    task set_start(input logic v);
        @(posedge i_clk);
        o_start_pin <= v;
    endtask
    task set_reset(input logic v);
        @(posedge i_clk);
        o_reset_pin <= v;
    endtask
    // The external clock stands low outside bursts.
    task ext_clocks(input int n);
        repeat (n) begin
            @(posedge i_clk);
            o_ext_clk <= 1'b1;
            repeat (2) @(posedge i_clk);
            o_ext_clk <= 1'b0;
            @(posedge i_clk);
        end
    endtask
endmodule

// file: bench/tb.sv
// Register-level testbench for the timer configuration block.
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module tb;
    logic       clk, rst, wr, rd;
    logic [2:0] addr, wave, cstop;
    logic [7:0] wdata, cmp0, rel0, t2c;
    wire  [7:0] rdata;
    wire  [2:0] treset, trun, irq;
    wire  [1:0] tick, pwm, sqw;
    wire        spin, rpin, xclk;
    int         fails, checks_done, i, k;
    logic [2:0] adr [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
    logic [7:0] msk [6] = '{8'hff, 8'h3f, 8'hff, 8'hf5, 8'h3f, 8'h00};
    logic [7:0] eex [3] = '{8'h01, 8'h01, 8'h02};
    logic [7:0] pcm [4] = '{8'h00, 8'hff, 8'h08, 8'h80};
    logic [7:0] pex [4] = '{8'h01, 8'h01, 8'h01, 8'h02};

    tpic_top dut (
        .i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_t0_start_stop_pin(spin), .i_t0_reset_pin(rpin),
        .i_t0_ext_clk_pin(xclk), .i_t2_control(t2c), .i_timer_wave_out(wave),
        .i_count_stop(cstop), .i_t0_compare(cmp0), .i_t0_reload(rel0),
        .i_t1_compare(cmp0), .i_t1_reload(rel0), .i_t2_compare(cmp0),
        .i_t2_reload(rel0), .o_timer_reset(treset), .o_timer_run(trun),
        .o_pwm_select(pwm), .o_square_wave(sqw), .o_prescaled_tick(tick), .o_irq(irq)
    );
    tpic_far far (
        .i_clk(clk), .i_irq(irq), .o_start_pin(spin), .o_reset_pin(rpin), .o_ext_clk(xclk)
    );

    task end_sim;
        $display("comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    task irq_win(input int n, input logic [7:0] e);
        repeat (n) @(posedge clk);
        `CHK(far.irq_cnt, e)
    endtask
    task cnt_tick(input int b, input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (tick[b] === 1'b1) c++;
        end
    endtask
    task tdone(input string s);
        $display("%s finished", s);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim;
    end
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        wave = 3'h0;
        cstop = 3'h0;
        cmp0 = 8'h80;
        rel0 = 8'h10;
        t2c = 8'h00;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK(treset, 3'h7)
        far.set_en(1'b0);
        for (i = 0; i < 6; i++) begin
            rd_chk(adr[i], 8'h00);
            wr_reg(adr[i], 8'hff);
            rd_chk(adr[i], msk[i]);
            wr_reg(adr[i], 8'h00);
        end
        far.set_en(1'b1);
        tdone("registers");
        t2c <= 8'h05;
        wr_reg(3'h3, 8'h05);
        repeat (3) @(posedge clk);
        #1;
        `CHK(treset[2:1], 2'h0)
        wr_reg(3'h2, 8'hc0);
        repeat (2) @(posedge clk);
        #1;
        `CHK(treset[2:1], 2'h3)
        wr_reg(3'h2, 8'h00);
        rd_chk(3'h5, 8'h16);
        tdone("sync hold");
        for (i = 0; i < 5; i++) begin
            wr_reg(3'h4, 8'h20 | i[7:0]);
            repeat (20) @(posedge clk);
            cnt_tick(1, 64, k);
            `CHK(k, 64 >> i)
            `CHK(sqw, 2'h2)
        end
        tdone("prescaler");
        wr_reg(3'h0, 8'h05);
        repeat (4) @(posedge clk);
        far.clear();
        cstop[0] <= 1'b1;
        @(posedge clk);
        cstop[0] <= 1'b0;
        irq_win(4, 8'h01);
        for (i = 0; i < 3; i++) begin
            wr_reg(3'h0, 8'h45 | (i[7:0] << 4));
            repeat (4) @(posedge clk);
            far.clear();
            wave[0] <= 1'b1;
            repeat (4) @(posedge clk);
            wave[0] <= 1'b0;
            irq_win(4, eex[i]);
        end
        tdone("interrupt modes");
        wr_reg(3'h0, 8'h51);
        repeat (4) @(posedge clk);
        far.clear();
        wr_reg(3'h0, 8'h55);
        irq_win(6, 8'h01);
        wr_reg(3'h0, 8'h45);
        repeat (4) @(posedge clk);
        far.clear();
        wr_reg(3'h0, 8'h44);
        irq_win(6, 8'h01);
        tdone("start and reset requests");
        for (i = 0; i < 4; i++) begin
            cmp0 <= pcm[i];
            wr_reg(3'h0, 8'hd1);
            repeat (4) @(posedge clk);
            far.clear();
            wr_reg(3'h0, 8'hd5);
            irq_win(4, pex[i] - 8'h01);
            wave[0] <= 1'b1;
            repeat (4) @(posedge clk);
            wave[0] <= 1'b0;
            irq_win(4, pex[i]);
            `CHK(pwm, 2'h1)
        end
        tdone("pwm suppression");
        wr_reg(3'h0, 8'h00);
        wr_reg(3'h2, 8'h04);
        far.set_start(1'b1);
        repeat (4) @(posedge clk);
        far.clear();
        far.set_start(1'b0);
        irq_win(6, 8'h01);
        wr_reg(3'h0, 8'h09);
        far.set_start(1'b1);
        far.set_start(1'b0);
        repeat (2) @(posedge clk);
        #1;
        `CHK(trun[0], 1'b1)
        tdone("external start request");
        wr_reg(3'h2, 8'h01);
        wr_reg(3'h0, 8'h05);
        far.set_reset(1'b1);
        repeat (3) @(posedge clk);
        #1;
        `CHK(treset[0], 1'b1)
        far.set_reset(1'b0);
        repeat (3) @(posedge clk);
        #1;
        `CHK(treset[0], 1'b0)
        wr_reg(3'h0, 8'h07);
        far.set_reset(1'b1);
        @(posedge clk);
        #1;
        `CHK(treset[0], 1'b1)
        @(posedge clk);
        #1;
        `CHK(treset[0], 1'b0)
        far.set_reset(1'b0);
        wr_reg(3'h2, 8'h10);
        repeat (20) @(posedge clk);
        fork
            far.ext_clocks(5);
            cnt_tick(0, 30, k);
        join
        `CHK(k, 5)
        tdone("external sources");
        end_sim;
    end
endmodule
